/* lcd_pkg.sv */
// Constants, register map and carrier types of the panel refresh controller
package lcd_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_LINE = 12'h004;
    localparam logic [11:0] OFF_TOTAL = 12'h008;
    localparam logic [11:0] OFF_BASE = 12'h00c;
    localparam logic [11:0] OFF_DIV = 12'h010;
    localparam logic [11:0] OFF_TIMING = 12'h014;
    localparam logic [11:0] OFF_STATUS = 12'h018;
    localparam logic [11:0] OFF_MASK = 12'h01c;
    localparam logic [11:0] OFF_LINES = 12'h020;
    localparam logic [1:0] PAL_REGION = 2'h1;
    // Geometry limits
    localparam logic [10:0] LINE_MIN = 11'h010;
    localparam logic [10:0] LINE_MAX = 11'h400;
    localparam logic [20:0] PIX_MAX = 21'h100000;
    // Storage sizes
    localparam int FIFO_DEPTH = 64;
    localparam logic [6:0] FIFO_FULL = 7'h40;
    localparam int PAL_DEPTH = 256;
    // Dither and fetch constants
    localparam logic [3:0] GREY_MAX = 4'he;
    localparam logic [3:0] DITH_LAST = 4'hd;
    localparam logic [31:0] ADDR_STEP = 32'h00000002;
    // Status bit positions
    localparam int ST_UNDERFLOW = 0;
    localparam int ST_FRAME = 1;
    // Reset values
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [10:0] LINE_RST = 11'h010;
    localparam logic [20:0] TOTAL_RST = 21'h000100;
    localparam logic [31:0] BASE_RST = 32'h00000000;
    localparam logic [7:0] DIV_RST = 8'h01;
    localparam logic [31:0] TIMING_RST = 32'h00020404;

    typedef enum logic [2:0] {
        D2 = 3'b000, D4 = 3'b001, D8 = 3'b010, D12 = 3'b011, D16 = 3'b100
    } depth_t;
    typedef enum logic [1:0] {
        PANEL_MONO = 2'b00, PANEL_PCOL = 2'b01, PANEL_ACT = 2'b10
    } panel_t;
    typedef enum logic {VS_ACTIVE = 1'b0, VS_BLANK = 1'b1} vstate_t;

    typedef struct packed {panel_t panel; depth_t depth; logic enable;} ctrl_t;
    typedef struct packed {
        logic [7:0] acb; logic [7:0] vblank; logic [7:0] hblank; logic [7:0] hsw;
    } timing_t;
    typedef struct packed {logic [3:0] r; logic [3:0] g; logic [3:0] b;} rgb12_t;
endpackage

/* lcd_refresh_ctrl.sv */
// Panel refresh controller: fetch FIFO, unpack, palette, dither, panel timing
//
// Overview of operation
// - Line length 16 to 1024 pixels, whole multiples of 16 only.
// - Line count follows from programmed total pixels; frames up to 1024x1024.
// - Frame buffer is one block; lines fetched from consecutive addresses.
// - Input FIFO holds 64 words of 16 bits.
// - Pixel depths 2, 4, 8, 12, 16 bits; words unpacked per depth.
// - Passive mono, passive colour and active colour panels; output formatted per type.
// - Dither gives 15 greys, 3375 passive colours, 65536 active colours.
// - 256 by 12-bit palette translates indexed pixels.
// - Programmable pixel clock with line and frame syncs.
// - Ac-bias output and display enable while active pixels shown, starved blank ones included.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
module lcd_refresh_ctrl import lcd_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic dma_valid,
    input wire logic [15:0] dma_data,
    output logic dma_ready,
    output logic [31:0] dma_addr,
    output logic pix_clk,
    output logic hsync,
    output logic vsync,
    output logic ac_bias,
    output logic de,
    output logic [15:0] pix_data,
    output logic irq
);
    // Last pixel slot inside one word
    function automatic logic [2:0] last_sub(depth_t d);
        case (d)
            D2: last_sub = 3'h7;
            D4: last_sub = 3'h3;
            D8: last_sub = 3'h1;
            default: last_sub = 3'h0;
        endcase
    endfunction

    // Frame-buffer words needed for a given pixel count
    function automatic logic [20:0] words_for(depth_t d, logic [20:0] px);
        case (d)
            D2: words_for = px >> 3;
            D4: words_for = px >> 2;
            D8: words_for = px >> 1;
            default: words_for = px;
        endcase
    endfunction

    // Bit offset of a pixel slot
    function automatic logic [3:0] px_shift(depth_t d, logic [2:0] s);
        case (d)
            D2: px_shift = {s, 1'b0};
            D4: px_shift = {s[1:0], 2'b00};
            D8: px_shift = {s[0], 3'b000};
            default: px_shift = 4'h0;
        endcase
    endfunction

    // Limit a colour nibble to the 15 dither levels
    function automatic logic [3:0] level(logic [3:0] n);
        level = (n > GREY_MAX) ? GREY_MAX : n;
    endfunction

    ctrl_t ctrl_reg;
    timing_t timing_reg;
    logic [10:0] line_len_reg;
    logic [20:0] total_reg;
    logic [31:0] base_reg;
    logic [7:0] div_reg;
    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    logic [10:0] lines_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;
    logic [11:0] palette [0:PAL_DEPTH-1];
    logic [15:0] fifo_mem [0:FIFO_DEPTH-1];
    logic [5:0] wr_ptr_reg;
    logic [5:0] rd_ptr_reg;
    logic [6:0] fifo_cnt_reg;
    logic dma_ready_reg;
    logic [31:0] dma_addr_reg;
    logic [20:0] fetch_cnt_reg;
    logic [15:0] word_reg;
    logic word_valid_reg;
    logic [2:0] sub_reg;
    logic [7:0] div_cnt_reg;
    logic pix_clk_reg;
    vstate_t vstate_reg;
    vstate_t vstate_next;
    logic [10:0] h_cnt_reg;
    logic [10:0] line_cnt_reg;
    logic [7:0] vline_reg;
    logic [20:0] pix_cnt_reg;
    logic [7:0] acb_cnt_reg;
    logic ac_bias_reg;
    logic hsync_reg;
    logic vsync_reg;
    logic de_reg;
    logic [15:0] pix_data_reg;
    logic [3:0] dith_reg;

    // Register write decode
    wire logic en = ctrl_reg.enable;
    wire logic wr_ctrl = bus_wr && bus_addr == OFF_CTRL;
    wire logic wr_line = bus_wr && bus_addr == OFF_LINE;
    wire logic wr_total = bus_wr && bus_addr == OFF_TOTAL;
    wire logic wr_base = bus_wr && bus_addr == OFF_BASE;
    wire logic wr_div = bus_wr && bus_addr == OFF_DIV;
    wire logic wr_timing = bus_wr && bus_addr == OFF_TIMING;
    wire logic wr_status = bus_wr && bus_addr == OFF_STATUS;
    wire logic wr_mask = bus_wr && bus_addr == OFF_MASK;
    wire logic in_pal = bus_addr[11:10] == PAL_REGION;
    wire logic wr_pal = bus_wr && in_pal;
    wire logic [7:0] pal_idx = bus_addr[9:2];

    // Line length snapped to the 16-pixel grid inside its range
    wire logic [10:0] line_wr = (bus_wdata < 32'(LINE_MIN)) ? LINE_MIN :
        (bus_wdata > 32'(LINE_MAX)) ? LINE_MAX : {bus_wdata[10:4], 4'h0};
    wire logic [20:0] total_wr =
        (bus_wdata > 32'(PIX_MAX)) ? PIX_MAX : bus_wdata[20:0];

    // Read data selection, unmapped reads give zero
    wire logic [31:0] rd_mux =
        (bus_addr == OFF_CTRL) ? {26'h0, ctrl_reg} :
        (bus_addr == OFF_LINE) ? {21'h0, line_len_reg} :
        (bus_addr == OFF_TOTAL) ? {11'h0, total_reg} :
        (bus_addr == OFF_BASE) ? base_reg :
        (bus_addr == OFF_DIV) ? {24'h0, div_reg} :
        (bus_addr == OFF_TIMING) ? timing_reg :
        (bus_addr == OFF_STATUS) ? {30'h0, status_reg} :
        (bus_addr == OFF_MASK) ? {30'h0, mask_reg} :
        (bus_addr == OFF_LINES) ? {21'h0, lines_reg} :
        in_pal ? {20'h0, palette[pal_idx]} : 32'h0;

    // Pixel rate divider and panel timing decode
    wire logic pix_tick = en && div_cnt_reg == div_reg;
    wire logic [10:0] h_last = 11'(line_len_reg + {3'h0, timing_reg.hblank} - 11'h1);
    wire logic h_end = h_cnt_reg == h_last;
    wire logic line_end = pix_tick && h_end;
    wire logic in_line = h_cnt_reg < line_len_reg;
    wire logic active_px = vstate_reg == VS_ACTIVE && in_line;
    wire logic [21:0] pix_after = {1'b0, pix_cnt_reg} + {11'h0, line_len_reg};
    wire logic frame_end = line_end && vstate_reg == VS_ACTIVE
        && pix_after >= {1'b0, total_reg};
    wire logic blank_end = line_end && vstate_reg == VS_BLANK
        && vline_reg >= timing_reg.vblank;
    wire logic hs_on = !in_line
        && h_cnt_reg < 11'(line_len_reg + {3'h0, timing_reg.hsw});

    // Vertical phase: active lines, then blank lines with frame sync
    always_comb begin
        vstate_next = vstate_reg;
        unique case (vstate_reg)
            VS_ACTIVE: begin
                if (frame_end) begin
                    vstate_next = VS_BLANK;
                end
            end
            VS_BLANK: begin
                if (blank_end) begin
                    vstate_next = VS_ACTIVE;
                end
            end
        endcase
    end

    // FIFO and fetch control
    wire logic flush = !en || frame_end;
    wire logic push = dma_valid && dma_ready_reg;
    wire logic pop = en && !word_valid_reg && fifo_cnt_reg != 7'h0;
    wire logic [6:0] fifo_cnt_next = flush ? 7'h0 :
        7'(fifo_cnt_reg + {6'h0, push} - {6'h0, pop});
    wire logic [20:0] fetch_next = flush ? 21'h0 : 21'(fetch_cnt_reg + {20'h0, push});
    wire logic fetch_left = fetch_next < words_for(ctrl_reg.depth, total_reg);

    // Pixel unpacking and colour lookup
    wire logic [15:0] shifted = word_reg >> px_shift(ctrl_reg.depth, sub_reg);
    wire logic [7:0] pal_pix = (ctrl_reg.depth == D2) ? {6'h0, shifted[1:0]} :
        (ctrl_reg.depth == D4) ? {4'h0, shifted[3:0]} : shifted[7:0];
    wire rgb12_t pal_col = palette[pal_pix];
    wire rgb12_t px_col = (ctrl_reg.depth == D12) ? rgb12_t'(word_reg[11:0]) :
        (ctrl_reg.depth == D16) ? {word_reg[15:12], word_reg[10:7], word_reg[4:1]} :
        pal_col;
    wire logic consume = pix_tick && active_px;
    wire logic starve = consume && !word_valid_reg;

    // Output formatting per panel type
    wire logic [15:0] act_out = (ctrl_reg.depth == D16) ? word_reg :
        {px_col.r, px_col.r[3], px_col.g, px_col.g[3:2], px_col.b, px_col.b[3]};
    wire logic mono_out = level(px_col.b) > dith_reg;
    wire logic [2:0] pcol_out = {level(px_col.r) > dith_reg, level(px_col.g) > dith_reg,
        level(px_col.b) > dith_reg};
    wire logic [15:0] fmt_out = (ctrl_reg.panel == PANEL_MONO) ? {15'h0, mono_out} :
        (ctrl_reg.panel == PANEL_PCOL) ? {13'h0, pcol_out} : act_out;

    // Status and interrupt next values, a new event beats a clear
    wire logic [1:0] events = {frame_end, starve};
    wire logic [1:0] clr = wr_status ? bus_wdata[1:0] : 2'h0;
    wire logic [1:0] status_next = (status_reg & ~clr) | events;
    wire logic [1:0] mask_next = wr_mask ? bus_wdata[1:0] : mask_reg;

    // Software registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= ctrl_t'(CTRL_RST);
            line_len_reg <= LINE_RST;
            total_reg <= TOTAL_RST;
            base_reg <= BASE_RST;
            div_reg <= DIV_RST;
            timing_reg <= timing_t'(TIMING_RST);
            status_reg <= 2'h0;
            mask_reg <= 2'h0;
            irq_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            if (wr_ctrl) ctrl_reg <= ctrl_t'(bus_wdata[5:0]);
            if (wr_line) line_len_reg <= line_wr;
            if (wr_total) total_reg <= total_wr;
            if (wr_base) base_reg <= {bus_wdata[31:1], 1'b0};
            if (wr_div) div_reg <= (bus_wdata[7:0] == 8'h0) ? DIV_RST : bus_wdata[7:0];
            if (wr_timing) timing_reg <= timing_t'(bus_wdata);
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= |(status_next & mask_next);
            rdata_reg <= bus_rd ? rd_mux : 32'h0;
        end
    end

    // Palette and FIFO storage
    always_ff @(posedge clk) begin
        if (wr_pal) palette[pal_idx] <= bus_wdata[11:0];
        if (push) fifo_mem[wr_ptr_reg] <= dma_data;
    end

    // FIFO pointers and sequential frame-buffer fetch
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= 6'h0;
            rd_ptr_reg <= 6'h0;
            fifo_cnt_reg <= 7'h0;
            fetch_cnt_reg <= 21'h0;
            dma_addr_reg <= BASE_RST;
            dma_ready_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= flush ? 6'h0 : 6'(wr_ptr_reg + {5'h0, push});
            rd_ptr_reg <= flush ? 6'h0 : 6'(rd_ptr_reg + {5'h0, pop});
            fifo_cnt_reg <= fifo_cnt_next;
            fetch_cnt_reg <= fetch_next;
            if (flush) begin
                dma_addr_reg <= base_reg;
            end else if (push) begin
                dma_addr_reg <= dma_addr_reg + ADDR_STEP;
            end
            dma_ready_reg <= en && fetch_left && fifo_cnt_next < FIFO_FULL;
        end
    end

    // Word holder and pixel slot
    always_ff @(posedge clk) begin
        if (rst || flush) begin
            word_reg <= 16'h0;
            word_valid_reg <= 1'b0;
            sub_reg <= 3'h0;
        end else if (pop) begin
            word_reg <= fifo_mem[rd_ptr_reg];
            word_valid_reg <= 1'b1;
            sub_reg <= 3'h0;
        end else if (consume && word_valid_reg) begin
            if (sub_reg == last_sub(ctrl_reg.depth)) begin
                word_valid_reg <= 1'b0;
            end
            sub_reg <= 3'(sub_reg + 3'h1);
        end
    end

    // Pixel clock divider
    always_ff @(posedge clk) begin
        if (rst || !en || pix_tick) begin
            div_cnt_reg <= 8'h0;
            pix_clk_reg <= 1'b0;
        end else begin
            div_cnt_reg <= 8'(div_cnt_reg + 8'h1);
            if (div_cnt_reg == (div_reg >> 1)) pix_clk_reg <= 1'b1;
        end
    end

    // Horizontal and vertical counters
    always_ff @(posedge clk) begin
        if (rst || !en) begin
            vstate_reg <= VS_BLANK;
            h_cnt_reg <= 11'h0;
            line_cnt_reg <= 11'h0;
            vline_reg <= 8'h0;
            pix_cnt_reg <= 21'h0;
            lines_reg <= rst ? 11'h0 : lines_reg;
        end else begin
            vstate_reg <= vstate_next;
            if (pix_tick) h_cnt_reg <= h_end ? 11'h0 : 11'(h_cnt_reg + 11'h1);
            if (frame_end) begin
                lines_reg <= 11'(line_cnt_reg + 11'h1);
                line_cnt_reg <= 11'h0;
                pix_cnt_reg <= 21'h0;
                vline_reg <= 8'h0;
            end else if (line_end && vstate_reg == VS_ACTIVE) begin
                line_cnt_reg <= 11'(line_cnt_reg + 11'h1);
                pix_cnt_reg <= pix_after[20:0];
            end else if (blank_end) begin
                vline_reg <= 8'h0;
            end else if (line_end) begin
                vline_reg <= 8'(vline_reg + 8'h1);
            end
        end
    end

    // Panel outputs, refreshed on each pixel tick
    always_ff @(posedge clk) begin
        if (rst || !en) begin
            hsync_reg <= 1'b0;
            vsync_reg <= 1'b0;
            de_reg <= 1'b0;
            pix_data_reg <= 16'h0;
            ac_bias_reg <= 1'b0;
            acb_cnt_reg <= 8'h0;
            dith_reg <= 4'h0;
        end else begin
            if (pix_tick) begin
                hsync_reg <= hs_on;
                vsync_reg <= vstate_reg == VS_BLANK && vline_reg == 8'h0;
                de_reg <= active_px;
                pix_data_reg <= (active_px && word_valid_reg) ? fmt_out : 16'h0;
            end
            if (consume) dith_reg <= (dith_reg == DITH_LAST) ? 4'h0 : 4'(dith_reg + 4'h1);
            if (line_end) begin
                acb_cnt_reg <= (acb_cnt_reg == timing_reg.acb) ? 8'h0 : 8'(acb_cnt_reg + 8'h1);
                if (acb_cnt_reg == timing_reg.acb) ac_bias_reg <= !ac_bias_reg;
            end
        end
    end

    assign bus_rdata = rdata_reg;
    assign dma_ready = dma_ready_reg;
    assign dma_addr = dma_addr_reg;
    assign pix_clk = pix_clk_reg;
    assign hsync = hsync_reg;
    assign vsync = vsync_reg;
    assign ac_bias = ac_bias_reg;
    assign de = de_reg;
    assign pix_data = pix_data_reg;
    assign irq = irq_reg;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_active_tick;
        pix_tick && active_px;
    endsequence
    sequence s_starved;
        s_active_tick ##0 !word_valid_reg;
    endsequence

    AST_LINE_GRID: assert property (line_len_reg[3:0] == 4'h0 && line_len_reg >= LINE_MIN
        && line_len_reg <= LINE_MAX) else $error("line length off grid");
    AST_FRAME_LINES: assert property (frame_end |=> status_reg[ST_FRAME]
        && lines_reg == 11'($past(line_cnt_reg) + 11'h1)) else $error("frame end lost");
    AST_ADDR_STEP: assert property (push && !flush |=>
        dma_addr_reg == $past(dma_addr_reg) + ADDR_STEP) else $error("address not sequential");
    AST_ADDR_RESTART: assert property (frame_end |=> dma_addr_reg == $past(base_reg))
        else $error("frame fetch not restarted");
    AST_FIFO_ROOM: assert property (push |-> fifo_cnt_reg < FIFO_FULL)
        else $error("push into full fifo");
    AST_SLOT_RANGE: assert property (word_valid_reg |-> sub_reg <= last_sub(ctrl_reg.depth))
        else $error("pixel slot out of range");
    AST_PASSIVE_WIDTH: assert property (de_reg && ctrl_reg.panel != PANEL_ACT
        |-> pix_data_reg[15:3] == 13'h0) else $error("passive data too wide");
    AST_MONO_BIT: assert property (de_reg && ctrl_reg.panel == PANEL_MONO
        |-> pix_data_reg[15:1] == 15'h0) else $error("mono data too wide");
    AST_PAL_WRITE: assert property (wr_pal |=>
        palette[$past(pal_idx)] == $past(bus_wdata[11:0])) else $error("palette not written");
    AST_TICK_GAP: assert property (pix_tick |=> !pix_tick)
        else $error("pixel ticks back to back");
    AST_DE_ACTIVE: assert property (s_active_tick |=> de_reg ##1 de_reg || pix_tick)
        else $error("display enable missing");
    AST_UNDERFLOW: assert property (s_starved |=> status_reg[ST_UNDERFLOW])
        else $error("underflow not flagged");
    AST_IRQ_LEVEL: assert property (##1 irq_reg == |(status_reg & mask_reg))
        else $error("interrupt level wrong");
endmodule

/* lcd_dma_model.sv */
// Memory-side DMA channel model that feeds frame-buffer words
`timescale 1ns/1ns
module lcd_dma_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic dma_ready,
    input wire logic [31:0] dma_addr,
    output logic dma_valid,
    output logic [15:0] dma_data
);
    integer seed = 84721;
    wire logic [15:0] fb_word = dma_addr[16:1] ^ 16'h3c5a;
    // Word follows the requested address, so a fetch restart never sees a stale word
    assign dma_data = dma_valid ? fb_word : ~fb_word;
    // Offer held until taken, withdrawn during a stall
    always @(posedge clk) begin
        if (rst || stall) begin
            dma_valid <= 1'b0;
        end else if (dma_valid && dma_ready) begin
            dma_valid <= 1'b0;
        end else if (!dma_valid && ($random(seed) & 3) != 0) begin
            dma_valid <= 1'b1;
        end
    end
endmodule

/* lcd_refresh_ctrl_tb_top.sv */
// Self-checking testbench of the panel refresh controller
`timescale 1ns/1ns
module lcd_refresh_ctrl_tb_top import lcd_pkg::*; ;
    logic clk = 0, rst = 1, bus_wr = 0, bus_rd = 0, stall = 0;
    logic [11:0] bus_addr = 12'h000;
    logic [31:0] bus_wdata = 32'h0, bus_rdata, dma_addr, base, rv;
    logic dma_valid, dma_ready, pix_clk, hsync, vsync, ac_bias, de, irq;
    logic [15:0] dma_data, pix_data;
    logic exp_zero = 0, mon_on = 0, seen_hs = 0, seen_vs = 0, acb_ch = 0, acb_l = 0;
    logic pclk_l = 0;
    logic [5:0] mode = 6'h29;
    integer seed = 84721, fail_count = 0, total_checks = 0, pix_idx = 0, cyc = 0, last_lo = 0;
    logic [11:0] offs [9] = '{OFF_CTRL, OFF_LINE, OFF_TOTAL, OFF_BASE, OFF_DIV,
        OFF_TIMING, OFF_STATUS, OFF_MASK, 12'h040};
    logic [31:0] rvals [9] = '{32'h0, 32'h10, 32'h100, 32'h0, 32'h1, 32'h00020404,
        32'h0, 32'h0, 32'h0};
    logic [11:0] cl_a [5] = '{OFF_LINE, OFF_LINE, OFF_LINE, OFF_TOTAL, OFF_DIV};
    logic [31:0] cl_w [5] = '{32'h5, 32'h7ff, 32'h35, 32'h1fffff, 32'h0};
    logic [31:0] cl_e [5] = '{32'h10, 32'h400, 32'h30, 32'h100000, 32'h1};

    lcd_refresh_ctrl u_dut (.clk(clk), .rst(rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready),
        .dma_addr(dma_addr), .pix_clk(pix_clk), .hsync(hsync), .vsync(vsync),
        .ac_bias(ac_bias), .de(de), .pix_data(pix_data), .irq(irq));
    lcd_dma_model u_dma (.clk(clk), .rst(rst), .stall(stall), .dma_ready(dma_ready),
        .dma_addr(dma_addr), .dma_valid(dma_valid), .dma_data(dma_data));

    // Clock, 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    function automatic logic [15:0] word_at(logic [31:0] a);
        return a[16:1] ^ 16'h3c5a;
    endfunction

    // Palette content used by the indexed modes
    function automatic logic [11:0] pal_val(logic [7:0] k);
        return 12'({4'h0, k} * 12'h25 + 12'h5);
    endfunction

    // Dither level of a colour nibble, 15 levels
    function automatic logic [3:0] lvl(logic [3:0] n);
        return (n > GREY_MAX) ? GREY_MAX : n;
    endfunction

    // Expected pixel of slot i for control value c, low pixels of a word first
    function automatic logic [15:0] exp_pix(logic [5:0] c, int i);
        int ppw;
        logic [15:0] w;
        logic [11:0] p;
        logic [3:0] d;
        ppw = (c[3:1] == 3'h0) ? 8 : (c[3:1] == 3'h1) ? 4 : (c[3:1] == 3'h2) ? 2 : 1;
        w = word_at(base + 32'(2 * ((i % 32) / ppw)));
        w = w >> ((16 / ppw) * ((i % 32) % ppw));
        d = 4'(i % 14);
        p = (ppw > 1) ? pal_val(8'(w & 16'((1 << (16 / ppw)) - 1))) :
            (c[3:1] == 3'h4) ? {w[15:12], w[10:7], w[4:1]} : w[11:0];
        if (c[3:1] == 3'h4 && c[5:4] == 2'h2) return w;
        case (c[5:4])
            2'h0: return {15'h0, (lvl(p[3:0]) > d)};
            2'h1: return {13'h0, (lvl(p[11:8]) > d), (lvl(p[7:4]) > d), (lvl(p[3:0]) > d)};
            default: return {p[11:8], p[11], p[7:4], p[7:6], p[3:0], p[3]};
        endcase
    endfunction

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(negedge clk);
        d = bus_rdata;
    endtask

    // Poll a status bit under a bound
    task automatic wait_status(int b);
        logic [31:0] s;
        int n;
        s = 0;
        for (n = 0; n < 2000 && s[b] !== 1'b1; n++) rd(OFF_STATUS, s);
        if (s[b] !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
    endtask

    // Pixel slot monitor, one sample in the first low cycle of each pixel clock
    always @(negedge clk) begin
        if (mon_on && pix_clk === 1'b0 && pclk_l === 1'b1) begin
            if (last_lo != 0) chk(32'(cyc - last_lo), 32'd4);
            last_lo = cyc;
            seen_hs |= (hsync === 1'b1);
            seen_vs |= (vsync === 1'b1);
            acb_ch |= (ac_bias !== acb_l);
            acb_l = ac_bias;
            if (de === 1'b1) begin
                chk(pix_data, exp_zero ? 32'h0 : 32'(exp_pix(mode, pix_idx)));
                pix_idx++;
            end
        end
        pclk_l = pix_clk;
    end

    // One frame of 16 by 2 pixels in the given control mode
    task automatic run_frame(logic [5:0] c, logic [31:0] mask, int b);
        wr(OFF_STATUS, 32'h3);
        wr(OFF_MASK, mask);
        mode = c;
        pix_idx = 0;
        last_lo = 0;
        mon_on = 1;
        wr(OFF_CTRL, 32'(c));
        wait_status(b);
        chk(irq, 1'b1);
        wait_status(ST_FRAME);
        mon_on = 0;
        wr(OFF_CTRL, 32'h0);
        chk(pix_idx, 32'd32);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd(offs[i], rv);
            chk(rv, rvals[i]);
        end
        // Clamping of geometry and divider
        for (int i = 0; i < 5; i++) begin
            wr(cl_a[i], cl_w[i]);
            rd(cl_a[i], rv);
            chk(rv, cl_e[i]);
        end
        // Palette entries hold 12 bits
        for (int i = 0; i < 6; i++) begin
            base = $random(seed);
            wr(12'h400 + {base[7:0], 2'b00}, base);
            rd(12'h400 + {base[7:0], 2'b00}, rv);
            chk(rv, base & 32'hfff);
        end
        base = $random(seed) & 32'h0000fffe;
        wr(OFF_BASE, base);
        wr(OFF_LINE, 32'h10);
        wr(OFF_TOTAL, 32'h20);
        wr(OFF_DIV, 32'h3);
        wr(OFF_TIMING, 32'h00000201);
        run_frame(6'h29, 32'h2, ST_FRAME);
        rd(OFF_LINES, rv);
        chk(rv, 32'h2);
        chk({seen_hs, seen_vs, acb_ch}, 3'b111);
        chk(de, 1'b0);
        wr(OFF_STATUS, 32'h2);
        rd(OFF_STATUS, rv);
        chk(rv, 32'h0);
        chk(irq, 1'b0);
        // Indexed, passive and low-depth modes
        for (int k = 0; k < 256; k++) wr(12'h400 + 12'(4 * k), 32'(pal_val(8'(k))));
        run_frame(6'h25, 32'h2, ST_FRAME);
        run_frame(6'h13, 32'h2, ST_FRAME);
        run_frame(6'h07, 32'h2, ST_FRAME);
        run_frame(6'h01, 32'h2, ST_FRAME);
        // Starved FIFO: blank pixels and underflow flag
        stall <= 1'b1;
        exp_zero = 1;
        run_frame(6'h29, 32'h1, ST_UNDERFLOW);
        wr(OFF_STATUS, 32'h3);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(irq, 1'b0);
        end_of_test();
    end

    initial begin
        #(100 * 90000);
        fail_count++;
        end_of_test();
    end
endmodule
